// ---- hdl/bstap_map.vh ----
// constants of the boundary-scan tap port
// Contract
// - mode select captured on each test clock rise advances the state machine
// - serial data input captured on each rise into the selected scan register
// - serial data output changes only on test clock falling edges
// - data output high impedance whenever no scan register is shifting
// - output enable changes only after a test clock falling edge
// - low test reset holds controller in reset and output high impedance
// - undriven mode select and data input read as logic one
`ifndef BSTAP_MAP_VH
`define BSTAP_MAP_VH
`define BSTAP_ST_RESET 4'h0
`define BSTAP_ST_IDLE 4'h1
`define BSTAP_ST_SELDR 4'h2
`define BSTAP_ST_CAPDR 4'h3
`define BSTAP_ST_SHDR 4'h4
`define BSTAP_ST_EX1DR 4'h5
`define BSTAP_ST_PAUDR 4'h6
`define BSTAP_ST_EX2DR 4'h7
`define BSTAP_ST_UPDR 4'h8
`define BSTAP_ST_SELIR 4'h9
`define BSTAP_ST_CAPIR 4'ha
`define BSTAP_ST_SHIR 4'hb
`define BSTAP_ST_EX1IR 4'hc
`define BSTAP_ST_PAUIR 4'hd
`define BSTAP_ST_EX2IR 4'he
`define BSTAP_ST_UPIR 4'hf
`define BSTAP_IR_W 4
`define BSTAP_IR_BYPASS 4'hf
`define BSTAP_IR_IDCODE 4'h1
`define BSTAP_IR_CAPT 4'h1
// arbitrary neutral identification value
`define BSTAP_IDCODE 32'h00000001
`define BSTAP_SYNC_W 6
`define BSTAP_PIN_CLK 0
`define BSTAP_PIN_MSEL 1
`define BSTAP_PIN_MSEL_OE 2
`define BSTAP_PIN_DIN 3
`define BSTAP_PIN_DIN_OE 4
`define BSTAP_PIN_RST 5
// idle levels: clock low, pins high, enables off, test reset on
`define BSTAP_SYNC_RST 6'h0a
`endif

// ---- hdl/bstap_port.v ----
// boundary-scan test access port, sampled on the system clock
`timescale 1ns/1ps
`include "bstap_map.vh"
module bstap_port
(
    input wire clk,
    input wire rst_n,
    input wire tap_clk,
    input wire tap_mode_sel,
    input wire tap_mode_sel_oe,
    input wire tap_data_in,
    input wire tap_data_in_oe,
    input wire tap_reset_n,
    output reg tap_data_out,
    output reg tap_data_out_oe
);
// ------------------------------------------------------------
// input synchronisers
// ------------------------------------------------------------
// pins and their enables pass two flops before any logic
wire [`BSTAP_SYNC_W-1:0] pinRaw;
wire [`BSTAP_SYNC_W-1:0] pinSync;
wire [`BSTAP_SYNC_W-1:0] pinRstVal;
wire tckS;
wire tmsS;
wire tdiS;
wire trstS;
assign pinRaw[`BSTAP_PIN_CLK] = tap_clk;
assign pinRaw[`BSTAP_PIN_MSEL] = tap_mode_sel;
assign pinRaw[`BSTAP_PIN_MSEL_OE] = tap_mode_sel_oe;
assign pinRaw[`BSTAP_PIN_DIN] = tap_data_in;
assign pinRaw[`BSTAP_PIN_DIN_OE] = tap_data_in_oe;
assign pinRaw[`BSTAP_PIN_RST] = tap_reset_n;
assign pinRstVal = `BSTAP_SYNC_RST;
genvar g;
generate
    for (g = 0; g < `BSTAP_SYNC_W; g = g + 1)
    begin : gSync
        bstap_sync uSync
        (
            .clk(clk),
            .rstN(rst_n),
            .rstVal(pinRstVal[g]),
            .din(pinRaw[g]),
            .dout(pinSync[g])
        );
    end
endgenerate
// ------------------------------------------------------------
// pull-ups on undriven inputs
// ------------------------------------------------------------
// value and enable resolved only after both are synchronised
assign tckS = pinSync[`BSTAP_PIN_CLK];
assign trstS = pinSync[`BSTAP_PIN_RST];
assign tmsS = pinSync[`BSTAP_PIN_MSEL_OE] ?
    pinSync[`BSTAP_PIN_MSEL] : 1'b1;
assign tdiS = pinSync[`BSTAP_PIN_DIN_OE] ?
    pinSync[`BSTAP_PIN_DIN] : 1'b1;
// ------------------------------------------------------------
// test clock edge detection
// ------------------------------------------------------------
// history resets low like the idle clock: no false rise after reset
reg tckPrev_r;
wire tckRise;
wire tckFall;
assign tckRise = tckS & ~tckPrev_r;
assign tckFall = ~tckS & tckPrev_r;
always @(posedge clk)
begin
    if (!rst_n)
        tckPrev_r <= 1'b0;
    else
        tckPrev_r <= tckS;
end
// ------------------------------------------------------------
// controller state machine
// ------------------------------------------------------------
// a low test reset overrides any clock edge
reg [3:0] state_r;
reg [3:0] state_nxt;
always @*
begin
    case (state_r)
        `BSTAP_ST_RESET:
            state_nxt = tmsS ? `BSTAP_ST_RESET : `BSTAP_ST_IDLE;
        `BSTAP_ST_IDLE:
            state_nxt = tmsS ? `BSTAP_ST_SELDR : `BSTAP_ST_IDLE;
        `BSTAP_ST_SELDR:
            state_nxt = tmsS ? `BSTAP_ST_SELIR : `BSTAP_ST_CAPDR;
        `BSTAP_ST_CAPDR:
            state_nxt = tmsS ? `BSTAP_ST_EX1DR : `BSTAP_ST_SHDR;
        `BSTAP_ST_SHDR:
            state_nxt = tmsS ? `BSTAP_ST_EX1DR : `BSTAP_ST_SHDR;
        `BSTAP_ST_EX1DR:
            state_nxt = tmsS ? `BSTAP_ST_UPDR : `BSTAP_ST_PAUDR;
        `BSTAP_ST_PAUDR:
            state_nxt = tmsS ? `BSTAP_ST_EX2DR : `BSTAP_ST_PAUDR;
        `BSTAP_ST_EX2DR:
            state_nxt = tmsS ? `BSTAP_ST_UPDR : `BSTAP_ST_SHDR;
        `BSTAP_ST_UPDR:
            state_nxt = tmsS ? `BSTAP_ST_SELDR : `BSTAP_ST_IDLE;
        `BSTAP_ST_SELIR:
            state_nxt = tmsS ? `BSTAP_ST_RESET : `BSTAP_ST_CAPIR;
        `BSTAP_ST_CAPIR:
            state_nxt = tmsS ? `BSTAP_ST_EX1IR : `BSTAP_ST_SHIR;
        `BSTAP_ST_SHIR:
            state_nxt = tmsS ? `BSTAP_ST_EX1IR : `BSTAP_ST_SHIR;
        `BSTAP_ST_EX1IR:
            state_nxt = tmsS ? `BSTAP_ST_UPIR : `BSTAP_ST_PAUIR;
        `BSTAP_ST_PAUIR:
            state_nxt = tmsS ? `BSTAP_ST_EX2IR : `BSTAP_ST_PAUIR;
        `BSTAP_ST_EX2IR:
            state_nxt = tmsS ? `BSTAP_ST_UPIR : `BSTAP_ST_SHIR;
        `BSTAP_ST_UPIR:
            state_nxt = tmsS ? `BSTAP_ST_SELDR : `BSTAP_ST_IDLE;
        default: state_nxt = `BSTAP_ST_RESET;
    endcase
end
always @(posedge clk)
begin
    if (!rst_n || !trstS)
        state_r <= `BSTAP_ST_RESET;
    else if (tckRise)
        state_r <= state_nxt;
end
// ------------------------------------------------------------
// instruction and data scan registers
// ------------------------------------------------------------
reg [`BSTAP_IR_W-1:0] irShift_r;
reg [`BSTAP_IR_W-1:0] ir_r;
reg [31:0] idShift_r;
reg bypass_r;
wire shiftDr;
wire shiftIr;
assign shiftDr = (state_r == `BSTAP_ST_SHDR);
assign shiftIr = (state_r == `BSTAP_ST_SHIR);
always @(posedge clk)
begin
    if (!rst_n || !trstS)
    begin
        irShift_r <= `BSTAP_IR_CAPT;
        ir_r <= `BSTAP_IR_IDCODE;
    end
    else if (tckRise)
    begin
        case (state_r)
            `BSTAP_ST_RESET:
                ir_r <= `BSTAP_IR_IDCODE;
            `BSTAP_ST_CAPIR:
                irShift_r <= `BSTAP_IR_CAPT;
            `BSTAP_ST_SHIR:
                irShift_r <= {tdiS, irShift_r[`BSTAP_IR_W-1:1]};
            `BSTAP_ST_UPIR:
                ir_r <= irShift_r;
            default:
                ir_r <= ir_r;
        endcase
    end
end
// ------------------------------------------------------------
// data register path: identification or bypass
// ------------------------------------------------------------
always @(posedge clk)
begin
    if (!rst_n || !trstS)
    begin
        idShift_r <= `BSTAP_IDCODE;
        bypass_r <= 1'b0;
    end
    else if (tckRise)
    begin
        case (state_r)
            `BSTAP_ST_CAPDR:
            begin
                idShift_r <= `BSTAP_IDCODE;
                bypass_r <= 1'b0;
            end
            `BSTAP_ST_SHDR:
            begin
                if (ir_r == `BSTAP_IR_IDCODE)
                    idShift_r <= {tdiS, idShift_r[31:1]};
                else
                    bypass_r <= tdiS;
            end
            default:
                bypass_r <= bypass_r;
        endcase
    end
end
// ------------------------------------------------------------
// serial output, retimed to the falling edge
// ------------------------------------------------------------
reg drBit;
reg outBit_nxt;
reg outOe_nxt;
always @*
begin
    if (ir_r == `BSTAP_IR_IDCODE)
        drBit = idShift_r[0];
    else
        drBit = bypass_r;
end
// held between falls; only a fall loads new values
always @*
begin
    outBit_nxt = tap_data_out;
    outOe_nxt = tap_data_out_oe;
    if (tckFall)
    begin
        outBit_nxt = shiftIr ? irShift_r[0] : drBit;
        outOe_nxt = shiftIr | shiftDr;
    end
end
always @(posedge clk)
begin
    if (!rst_n || !trstS)
    begin
        tap_data_out <= 1'b0;
        tap_data_out_oe <= 1'b0;
    end
    else
    begin
        tap_data_out <= outBit_nxt;
        tap_data_out_oe <= outOe_nxt;
    end
end
endmodule

// ---- hdl/bstap_sync.v ----
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module bstap_sync
(
    input wire clk,
    input wire rstN,
    input wire rstVal,
    input wire din,
    output reg dout
);
reg meta_r;
always @(posedge clk)
begin
    if (!rstN)
    begin
        meta_r <= rstVal;
        dout <= rstVal;
    end
    else
    begin
        meta_r <= din;
        dout <= meta_r;
    end
end
endmodule

// ---- sim/bstap_ctl_model.sv ----
// test controller model driving the tap pins
`timescale 1ns/1ps
module bstap_ctl_model
(
    input wire clk,
    input wire tdo,
    input wire tdoOe,
    output reg tapClk,
    output reg tms,
    output reg tmsOe,
    output reg tdi,
    output reg tdiOe
);
initial
begin
    tapClk = 1'b0;
    tms = 1'b1;
    tmsOe = 1'b1;
    tdi = 1'b0;
    tdiOe = 1'b1;
end
// one test clock period; released lines show the inverse
task step(input m, input mOe, input d, output q, output qOe);
begin
    tms = mOe ? m : ~tms;
    tdi = mOe ? d : ~tdi;
    tmsOe = mOe;
    tdiOe = mOe;
    repeat (4) @(negedge clk);
    tapClk = 1'b1;
    repeat (4) @(negedge clk);
    q = tdo;
    qOe = tdoOe;
    tapClk = 1'b0;
end
endtask
endmodule

// ---- sim/bstap_port_asserts.sv ----
// assertions on the tap port pins
`timescale 1ns/1ps
module bstap_port_asserts
(
    input wire clk,
    input wire rst_n,
    input wire tap_clk,
    input wire tap_reset_n,
    input wire tap_data_out,
    input wire tap_data_out_oe
);
reg tapClk_r;
reg [3:0] sinceFall_r;
always @(posedge clk)
begin
    tapClk_r <= tap_clk;
    if (!rst_n)
        sinceFall_r <= 4'hf;
    else if (tapClk_r && !tap_clk)
        sinceFall_r <= 4'h0;
    else if (sinceFall_r != 4'hf)
        sinceFall_r <= sinceFall_r + 4'h1;
end
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
AST_OUT_FALL: assert property ($changed(tap_data_out) && tap_reset_n
    |-> sinceFall_r < 4'h7) else $error("out moved off a fall");
AST_OE_FALL: assert property ($changed(tap_data_out_oe) && tap_reset_n
    |-> sinceFall_r < 4'h7) else $error("enable moved off a fall");
AST_TRST_HIZ: assert property (!tap_reset_n [*4]
    |-> !tap_data_out_oe) else $error("driving in test reset");
AST_TRST_PROMPT: assert property ($fell(tap_reset_n)
    |-> ##[1:5] !tap_data_out_oe) else $error("slow test reset");
AST_OUT_HIGH: assert property ((tap_clk && tap_reset_n) [*4]
    |-> $stable(tap_data_out)) else $error("out moved in high half");
AST_OE_HIGH: assert property ((tap_clk && tap_reset_n) [*4]
    |-> $stable(tap_data_out_oe)) else $error("enable moved in high");
AST_OUT_IDLE: assert property ((!tap_clk && tap_reset_n) [*8]
    |-> $stable(tap_data_out)) else $error("out moved while idle");
AST_OE_IDLE: assert property ((!tap_clk && tap_reset_n) [*8]
    |-> $stable(tap_data_out_oe)) else $error("enable moved idle");
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the tap port
`timescale 1ns/1ps
module tb_top;
reg clk, rst_n, tapResetN, q, qOe, oeAll;
wire tapClk, tms, tmsOe, tdi, tdiOe, tdo, tdoOe;
integer errors = 0;
integer num_checks = 0;
integer i, r;
reg [31:0] got;
reg [67:0] rows [0:2];
bstap_port i_bstap_port (.clk(clk), .rst_n(rst_n), .tap_clk(tapClk),
    .tap_mode_sel(tms), .tap_mode_sel_oe(tmsOe), .tap_data_in(tdi),
    .tap_data_in_oe(tdiOe), .tap_reset_n(tapResetN),
    .tap_data_out(tdo), .tap_data_out_oe(tdoOe));
bstap_ctl_model i_bstap_ctl_model (.clk(clk), .tdo(tdo), .tdoOe(tdoOe),
    .tapClk(tapClk), .tms(tms), .tmsOe(tmsOe), .tdi(tdi), .tdiOe(tdiOe));
task chk(input [47:0] nm, input [31:0] exp, input [31:0] seen);
begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
        errors = errors + 1;
        $display("wrong value %0s exp %h got %h", nm, exp, seen);
    end
end
endtask
task st(input m, input d);
    i_bstap_ctl_model.step(m, 1'b1, d, q, qOe);
endtask
task walk(input [7:0] seq, input integer n);
    integer k;
begin
    for (k = 0; k < n; k = k + 1)
        st(seq[k], 1'b0);
end
endtask
task conclude;
begin
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
end
endtask
initial
begin
    clk = 1'b0;
    forever #25 clk = ~clk;
end
initial
begin
    #200000;
    errors = errors + 1;
    conclude;
end
initial
begin
    rows[0] = {4'h1, 32'h00000000, 32'h00000001};
    rows[1] = {4'hf, 32'ha5c30f96, 32'h4b861f2c};
    rows[2] = {4'h7, 32'h0000ffff, 32'h0001fffe};
    rst_n = 1'b0;
    tapResetN = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("rst", 32'h0, {30'h0, tdo, tdoOe});
    tapResetN = 1'b1;
    repeat (4) @(negedge clk);
    walk(8'h1f, 5);
    st(1'b0, 1'b0);
    for (r = 0; r < 3; r = r + 1)
    begin
        walk(8'h03, 4);
        for (i = 0; i < 4; i = i + 1)
            st(i == 3, rows[r][64 + i]);
        walk(8'h03, 4);
        oeAll = 1'b1;
        for (i = 0; i < 32; i = i + 1)
        begin
            st(i == 31, rows[r][32 + i]);
            got[i] = q;
            oeAll = oeAll & qOe;
        end
        walk(8'h01, 2);
        chk("dr", rows[r][31:0], got);
        chk("oe", 32'h2, {30'h0, oeAll, qOe});
    end
    walk(8'h01, 3);
    st(1'b0, 1'b0);
    for (i = 0; i < 5; i = i + 1)
        i_bstap_ctl_model.step(1'b0, 1'b0, 1'b0, q, qOe);
    chk("pullup", 32'h0, {31'h0, qOe});
    st(1'b0, 1'b0);
    walk(8'h01, 3);
    st(1'b0, 1'b0);
    chk("idbit", 32'h3, {30'h0, q, qOe});
    tapResetN = 1'b0;
    repeat (8) @(negedge clk);
    chk("trst", 32'h0, {31'h0, tdoOe});
    conclude;
end
endmodule
bind bstap_port bstap_port_asserts i_bstap_port_asserts (.clk(clk),
    .rst_n(rst_n), .tap_clk(tap_clk), .tap_reset_n(tap_reset_n),
    .tap_data_out(tap_data_out), .tap_data_out_oe(tap_data_out_oe));
